// file: design/psc_pkg.sv
package psc_pkg;
  // instruction word layout: pattern | operand | opcode | duration (pattern in the top bits)
  localparam int WORD_W     = 80;            // width of one program word
  localparam int PAT_W      = 24;            // output pattern width
  localparam int OPD_W      = 20;            // operand width
  localparam int OPC_W      = 4;             // opcode width
  localparam int DUR_W      = 32;            // duration count width
  localparam int DUR_LSB    = 0;             // duration field position
  localparam int OPC_LSB    = 32;            // opcode field position
  localparam int OPD_LSB    = 36;            // operand field position
  localparam int PAT_LSB    = 56;            // pattern field position
  localparam int ADDR_W     = 10;            // program address width
  localparam int STK_DEPTH  = 8;             // nesting depth of call and loop stacks
  localparam int STK_W      = 3;             // stack pointer width
  localparam int MIN_DUR    = 5;             // shortest instruction in cycles
  localparam int WAIT_FIXED = 6;             // fixed exit latency of a trigger wait
  localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000; // start address
  localparam logic [PAT_W-1:0]  PAT_RST  = 24'h000000; // outputs after reset

  typedef enum logic [OPC_W-1:0] {
    OP_ADVANCE = 4'h0, OP_HALT = 4'h1, OP_LOOP_BEGIN = 4'h2, OP_LOOP_END = 4'h3,
    OP_CALL = 4'h4, OP_RETURN = 4'h5, OP_JUMP = 4'h6, OP_LONG_DELAY = 4'h7, OP_TRIG_WAIT = 4'h8
  } psc_opcode_e;
endpackage : psc_pkg

// file: design/psc_prog_mem.sv
`timescale 1ns/10ps
// program memory: one full instruction per location, registered read port
module psc_prog_mem (
  input  wire logic                           clock_i,   // reference clock
  input  wire logic                           wr_en_i,   // host write strobe
  input  wire logic [psc_pkg::ADDR_W-1:0]     wr_addr_i, // host write address
  input  wire logic [psc_pkg::WORD_W-1:0]     wr_data_i, // host write word
  input  wire logic [psc_pkg::ADDR_W-1:0]     rd_addr_i, // fetch address
  output logic      [psc_pkg::WORD_W-1:0]     rd_data_o  // fetched word, one cycle later
);
  logic [psc_pkg::WORD_W-1:0] mem [0:(1<<psc_pkg::ADDR_W)-1]; // storage array

  // write port and registered read port
  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule : psc_prog_mem

// file: design/psc_core.sv
`timescale 1ns/10ps
// How it works
// - each memory word is one full instruction
// - fields are pattern, operand, opcode, duration
// - pattern drives outputs during whole instruction
// - duration at least five cycles, 32-bit
// - fetch, show pattern, wait, then act
// - advance goes to next instruction
// - halt stops at once, outputs kept
// - loop begin loads count, moves on
// - loop end returns to start, decrements
// - call jumps and saves return address
// - return resumes after latest call
// - jump goes to operand address
// - long delay holds duration times operand
// - trigger wait stops until trigger arrives
// - wait exit takes duration plus six
// - trigger resumes wait, restarts when halted
// - external restart returns to idle and rewinds
// - status outputs for halted, running, waiting, reset
module psc_core (
  input  wire logic                       clock_i,         // reference clock, 25 MHz
  input  wire logic                       resetn_i,        // asynchronous reset, active low
  input  wire logic                       prog_wr_i,       // program word write strobe
  input  wire logic [psc_pkg::ADDR_W-1:0] prog_addr_i,     // program word address
  input  wire logic [psc_pkg::WORD_W-1:0] prog_data_i,     // program word
  input  wire logic                       start_i,         // software start pulse
  input  wire logic                       stop_i,          // software stop pulse
  input  wire logic                       sw_trigger_i,    // software trigger pulse
  input  wire logic                       ext_trigger_n_i, // header trigger pin, active low
  input  wire logic                       ext_restart_n_i, // header restart pin, active low
  output logic      [psc_pkg::PAT_W-1:0]  pattern_o,       // output pattern
  output logic                            halted_o,        // high after halt opcode
  output logic                            running_o,       // high while executing
  output logic                            waiting_o,       // high in trigger wait
  output logic                            reset_n_o        // low while in reset state
);
  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_DECODE, S_HOLD, S_WAIT, S_EXIT, S_HALT} psc_state_e;

  psc_state_e                      state;       // sequencer state
  logic [psc_pkg::ADDR_W-1:0]      pc;          // current instruction address
  logic [psc_pkg::WORD_W-1:0]      word;        // fetched word from memory
  logic [psc_pkg::WORD_W-1:0]      cur;         // latched current instruction
  logic [63:0]                     cnt;         // remaining hold cycles
  logic [psc_pkg::ADDR_W-1:0]      ret_stk [0:psc_pkg::STK_DEPTH-1]; // return addresses
  logic [psc_pkg::OPD_W-1:0]       lp_stk  [0:psc_pkg::STK_DEPTH-1]; // loop counters
  logic [psc_pkg::STK_W-1:0]       rsp;         // return stack pointer
  logic [psc_pkg::STK_W-1:0]       lsp;         // loop stack pointer
  logic [2:0]                      trg_sync;    // trigger synchroniser and edge stage
  logic [1:0]                      rst_sync;    // restart synchroniser
  logic                            trg_fall;    // trigger falling edge
  logic                            trig;        // any trigger
  logic [psc_pkg::OPC_W-1:0]       opc;         // opcode of current instruction
  logic [psc_pkg::OPD_W-1:0]       opd;         // operand of current instruction
  logic [psc_pkg::DUR_W-1:0]       dur;         // duration of current instruction
  logic [psc_pkg::ADDR_W-1:0]      pc_inc;      // next sequential address
  logic [psc_pkg::ADDR_W-1:0]      next_pc;     // address after current action
  logic                            lp_more;     // loop counter still above one

  // field extraction of a program word
  function automatic logic [psc_pkg::DUR_W-1:0] f_dur(input logic [psc_pkg::WORD_W-1:0] w);
    f_dur = w[psc_pkg::DUR_LSB +: psc_pkg::DUR_W];
  endfunction : f_dur

  // hold length: duration, floored at the minimum, and the fetch cycles already spent
  function automatic logic [63:0] f_hold(input logic [psc_pkg::DUR_W-1:0] d, input logic [psc_pkg::OPD_W-1:0] m);
    logic [63:0] t;
    t = 64'(d < psc_pkg::DUR_W'(psc_pkg::MIN_DUR) ? psc_pkg::DUR_W'(psc_pkg::MIN_DUR) : d);
    f_hold = t * 64'(m) - 64'h3; // fetch, decode and last hold cycle included
  endfunction : f_hold

  psc_prog_mem u_mem (
    .clock_i   (clock_i),
    .wr_en_i   (prog_wr_i),
    .wr_addr_i (prog_addr_i),
    .wr_data_i (prog_data_i),
    .rd_addr_i (pc),
    .rd_data_o (word)
  );

  assign opc      = cur[psc_pkg::OPC_LSB +: psc_pkg::OPC_W];
  assign opd      = cur[psc_pkg::OPD_LSB +: psc_pkg::OPD_W];
  assign dur      = f_dur(cur);
  assign pc_inc   = pc + psc_pkg::ADDR_W'(1);
  assign trg_fall = trg_sync[2] & ~trg_sync[1];
  assign trig     = trg_fall | sw_trigger_i;
  assign lp_more  = lp_stk[lsp - psc_pkg::STK_W'(1)] > psc_pkg::OPD_W'(1);

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trg_sync <= 3'h7;
      rst_sync <= 2'h3;
    end else begin
      trg_sync <= {trg_sync[1:0], ext_trigger_n_i};
      rst_sync <= {rst_sync[0], ext_restart_n_i};
    end
  end

  // control-flow target once the hold ends
  always_comb begin
    next_pc = pc_inc;
    case (opc)
      psc_pkg::OP_LOOP_END: next_pc = lp_more ? opd[psc_pkg::ADDR_W-1:0] : pc_inc;
      psc_pkg::OP_CALL:     next_pc = opd[psc_pkg::ADDR_W-1:0];
      psc_pkg::OP_RETURN:   next_pc = ret_stk[rsp - psc_pkg::STK_W'(1)];
      psc_pkg::OP_JUMP:     next_pc = opd[psc_pkg::ADDR_W-1:0];
      default:              next_pc = pc_inc;
    endcase
  end

  // sequencer: fetch, decode, hold, act
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= S_IDLE;
      pc    <= psc_pkg::ADDR_RST;
      cur   <= '0;
      cnt   <= '0;
    end else if (!rst_sync[1] || stop_i) begin
      state <= S_IDLE;
      pc    <= psc_pkg::ADDR_RST;
    end else begin
      case (state)
        S_IDLE, S_HALT: begin
          if (start_i || trig) begin
            pc    <= psc_pkg::ADDR_RST;
            state <= S_FETCH;
          end
        end
        S_FETCH: state <= S_DECODE; // memory read latency
        S_DECODE: begin
          cur <= word;
          if (word[psc_pkg::OPC_LSB +: psc_pkg::OPC_W] == psc_pkg::OP_HALT) begin
            state <= S_HALT;
          end else if (word[psc_pkg::OPC_LSB +: psc_pkg::OPC_W] == psc_pkg::OP_TRIG_WAIT) begin
            state <= S_WAIT;
          end else begin
            cnt <= f_hold(f_dur(word),
                          word[psc_pkg::OPC_LSB +: psc_pkg::OPC_W] == psc_pkg::OP_LONG_DELAY ?
                          word[psc_pkg::OPD_LSB +: psc_pkg::OPD_W] : psc_pkg::OPD_W'(1));
            state <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (cnt == 64'h0) begin
            pc    <= next_pc;
            state <= S_FETCH;
          end else begin
            cnt <= cnt - 64'h1;
          end
        end
        S_WAIT: begin
          if (trig) begin
            cnt   <= 64'(dur) + 64'(psc_pkg::WAIT_FIXED) - 64'h1;
            state <= S_EXIT;
          end
        end
        S_EXIT: begin
          if (cnt == 64'h0) begin
            pc    <= pc_inc;
            state <= S_FETCH;
          end else begin
            cnt <= cnt - 64'h1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // call and loop stacks
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rsp <= '0;
      lsp <= '0;
    end else if (!rst_sync[1] || stop_i || ((state == S_IDLE || state == S_HALT) && (start_i || trig))) begin
      rsp <= '0;
      lsp <= '0;
    end else if (state == S_HOLD && cnt == 64'h0) begin
      case (opc)
        psc_pkg::OP_CALL: begin
          ret_stk[rsp] <= pc_inc;
          rsp          <= rsp + psc_pkg::STK_W'(1);
        end
        psc_pkg::OP_RETURN: rsp <= rsp - psc_pkg::STK_W'(1);
        psc_pkg::OP_LOOP_BEGIN: begin
          lp_stk[lsp] <= opd;
          lsp         <= lsp + psc_pkg::STK_W'(1);
        end
        psc_pkg::OP_LOOP_END: begin
          if (lp_more) begin
            lp_stk[lsp - psc_pkg::STK_W'(1)] <= lp_stk[lsp - psc_pkg::STK_W'(1)] - psc_pkg::OPD_W'(1);
          end else begin
            lsp <= lsp - psc_pkg::STK_W'(1);
          end
        end
        default: rsp <= rsp;
      endcase
    end
  end

  // output pattern follows each decoded instruction, trigger wait included; halt keeps the old one
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pattern_o <= psc_pkg::PAT_RST;
    end else if (state == S_DECODE && word[psc_pkg::OPC_LSB +: psc_pkg::OPC_W] != psc_pkg::OP_HALT) begin
      pattern_o <= word[psc_pkg::PAT_LSB +: psc_pkg::PAT_W];
    end
  end

  // status outputs
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      halted_o  <= 1'b0;
      running_o <= 1'b0;
      waiting_o <= 1'b0;
      reset_n_o <= 1'b0;
    end else begin
      halted_o  <= (state == S_HALT);
      running_o <= (state != S_IDLE) && (state != S_HALT) && (state != S_WAIT);
      waiting_o <= (state == S_WAIT);
      reset_n_o <= (state != S_IDLE);
    end
  end

  // checks
  hold_pattern_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == S_HOLD) |=> $stable(pattern_o)) else $error("pattern moved during hold");
  halt_stop_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == S_DECODE && word[psc_pkg::OPC_LSB +: psc_pkg::OPC_W] == psc_pkg::OP_HALT && rst_sync[1] && !stop_i)
    |=> state == S_HALT ##1 halted_o) else $error("halt not taken");
  wait_exit_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == S_WAIT && trig && rst_sync[1] && !stop_i) |=> state == S_EXIT) else $error("wait missed trigger");
  restart_rewind_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !rst_sync[1] |=> state == S_IDLE && pc == psc_pkg::ADDR_RST) else $error("restart ignored");
  wait_flag_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == S_WAIT) |=> waiting_o) else $error("wait flag wrong");
  jump_target_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == S_HOLD && cnt == 64'h0 && opc == psc_pkg::OP_JUMP && rst_sync[1] && !stop_i)
    |=> pc == $past(opd[psc_pkg::ADDR_W-1:0])) else $error("jump target wrong");
  advance_next_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == S_HOLD && cnt == 64'h0 && opc == psc_pkg::OP_ADVANCE && rst_sync[1] && !stop_i)
    |=> pc == $past(pc) + psc_pkg::ADDR_W'(1)) else $error("advance wrong");
  hold_min_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == S_DECODE && rst_sync[1] && !stop_i && word[psc_pkg::OPC_LSB +: psc_pkg::OPC_W] == psc_pkg::OP_ADVANCE)
    |=> state == S_HOLD [*2]) else $error("hold too short");
  cov_halt: cover property (@(posedge clock_i) state == S_HALT);
  cov_wait: cover property (@(posedge clock_i) state == S_EXIT);
  cov_loop: cover property (@(posedge clock_i) state == S_HOLD && opc == psc_pkg::OP_LOOP_END && lp_more);
endmodule : psc_core

// file: testbench/psc_host_model.sv
`timescale 1ns/10ps
// host and header model: program loader, command strobes, trigger and restart pins
module psc_host_model (
  input  wire logic                       clock_i,         // reference clock
  output logic                            prog_wr_o,       // word write strobe
  output logic      [psc_pkg::ADDR_W-1:0] prog_addr_o,     // word address
  output logic      [psc_pkg::WORD_W-1:0] prog_data_o,     // word bits
  output logic                            start_o,         // start command
  output logic                            stop_o,          // stop command
  output logic                            sw_trigger_o,    // software trigger
  output logic                            ext_trigger_n_o, // trigger pin, pulled high
  output logic                            ext_restart_n_o  // restart pin, pulled high
);
  logic [1:0] cmd; // command on the strobes: 0 none, 1 start, 2 stop, 3 trigger

  // one command code drives the three strobes, so at most one is ever high
  assign start_o      = (cmd == 2'h1);
  assign stop_o       = (cmd == 2'h2);
  assign sw_trigger_o = (cmd == 2'h3);

  // idle levels: no command, write strobe low, header pins at their pull-up level
  initial begin
    cmd                                = 2'h0;
    prog_wr_o                          = 1'b0;
    {ext_trigger_n_o, ext_restart_n_o} = 2'h3;
  end

  // one whole word per strobe; callers keep durations of 5 or more, loop counts of 1 or more,
  // delay factors of 2 or more, and never place a wait first
  task automatic load(input logic [9:0] a, input logic [3:0] opc, input logic [19:0] opd,
                      input logic [23:0] pat, input logic [31:0] dur);
    @(posedge clock_i) #1;
    prog_wr_o   = 1'b1;
    prog_addr_o = a;
    prog_data_o = {pat, opd, opc, dur};
    @(posedge clock_i) #1;
    prog_wr_o   = 1'b0;
    prog_data_o = ~prog_data_o; // a released bus shows no stale word
  endtask : load

  // one-cycle command pulse; returns just after the edge that samples it
  task automatic pulse(input int k);
    @(posedge clock_i) #1;
    cmd = 2'(k + 1);
    @(posedge clock_i) #1;
    cmd = 2'h0;
  endtask : pulse

  // pull a header pin low for six cycles, then the pull-up restores it
  task automatic pin_low(input bit restart);
    @(posedge clock_i) #1;
    if (restart) ext_restart_n_o = 1'b0;
    else ext_trigger_n_o = 1'b0;
    repeat (6) @(posedge clock_i);
    #1 {ext_trigger_n_o, ext_restart_n_o} = 2'h3;
  endtask : pin_low
endmodule : psc_host_model

// file: testbench/psc_core_tb_top.sv
`timescale 1ns/10ps
// runs two programs through the core and checks patterns, stand times and status flags
module psc_core_tb_top;
  logic                       clock_i, resetn_i;             // clock and reset
  logic                       prog_wr, start, stop, sw_trig; // host strobes
  logic                       trig_n, restart_n;             // header pins
  logic [psc_pkg::ADDR_W-1:0] prog_addr;                     // word address
  logic [psc_pkg::WORD_W-1:0] prog_data;                     // word bits
  logic [23:0]                pattern, last_pat = 24'h0;     // outputs and last seen
  logic                       halted, running, waiting, reset_n; // status flags
  logic [23:0]                seg_pat[$];                    // finished patterns
  int                         seg_len[$];                    // their stand times
  int                         run_len = 0;                   // cycles the current pattern has stood
  int                         n, err_total, num_checks;      // wait count and tallies
  logic [23:0] exp_pat [11] = '{24'h1, 24'h2, 24'h3, 24'h4, 24'h3, 24'h4, 24'h5, 24'ha, 24'hb, 24'h6, 24'hc};
  int          exp_len [11] = '{5, 6, 7, 5, 7, 5, 8, 5, 6, 5, 15};

  always #20 clock_i = ~clock_i; // 25 MHz

  psc_host_model u_psc_host_model (.clock_i(clock_i), .prog_wr_o(prog_wr), .prog_addr_o(prog_addr),
    .prog_data_o(prog_data), .start_o(start), .stop_o(stop), .sw_trigger_o(sw_trig),
    .ext_trigger_n_o(trig_n), .ext_restart_n_o(restart_n));

  psc_core u_psc_core (.clock_i(clock_i), .resetn_i(resetn_i), .prog_wr_i(prog_wr), .prog_addr_i(prog_addr),
    .prog_data_i(prog_data), .start_i(start), .stop_i(stop), .sw_trigger_i(sw_trig),
    .ext_trigger_n_i(trig_n), .ext_restart_n_i(restart_n), .pattern_o(pattern), .halted_o(halted),
    .running_o(running), .waiting_o(waiting), .reset_n_o(reset_n));

  // segment recorder: stand time in cycles of each pattern as it ends
  always @(negedge clock_i) begin
    if (pattern !== last_pat) begin
      seg_pat.push_back(last_pat);
      seg_len.push_back(run_len);
      last_pat = pattern;
      run_len  = 1;
    end else begin
      run_len++;
    end
  end

  // compare one value, count it, report a difference
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      err_total++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, want);
    end
  endtask : check

  // print counts and verdict, then stop
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // bounded wait: k=0 for a pattern, 1 for halted, 2 for waiting; n counts edges
  task automatic wait_for(input int k, input logic [23:0] p, output int n);
    n = 0;
    while (!((k == 0) ? (pattern === p) : (((k == 1) ? halted : waiting) === 1'b1))) begin
      @(posedge clock_i) #1;
      n++;
      if (n > 2000) begin
        err_total++;
        $display("BAD %0t wait ran out", $time);
        wrap_up();
      end
    end
  endtask : wait_for

  initial begin
    {clock_i, resetn_i, err_total, num_checks} = '0;
    repeat (2) @(posedge clock_i);
    #1 resetn_i = 1'b1;
    check(reset_n, 1'b0);
    check(running, 1'b0);
    u_psc_host_model.load(10'h0, 4'h0, 20'h0, 24'h1, 32'h5);
    u_psc_host_model.load(10'h1, 4'h2, 20'h2, 24'h2, 32'h6);
    u_psc_host_model.load(10'h2, 4'h0, 20'h0, 24'h3, 32'h7);
    u_psc_host_model.load(10'h3, 4'h3, 20'h2, 24'h4, 32'h5);
    u_psc_host_model.load(10'h4, 4'h4, 20'ha, 24'h5, 32'h8);
    u_psc_host_model.load(10'h5, 4'h6, 20'hc, 24'h6, 32'h5);
    u_psc_host_model.load(10'ha, 4'h9, 20'h0, 24'ha, 32'h5);
    u_psc_host_model.load(10'hb, 4'h5, 20'h0, 24'hb, 32'h6);
    u_psc_host_model.load(10'hc, 4'h7, 20'h3, 24'hc, 32'h5);
    u_psc_host_model.load(10'hd, 4'h0, 20'h0, 24'hd, 32'h6);
    u_psc_host_model.load(10'he, 4'h1, 20'h0, 24'he, 32'h5);
    seg_pat.delete();
    seg_len.delete();
    u_psc_host_model.pulse(0);
    repeat (2) @(posedge clock_i);
    #1 check(running, 1'b1);
    check(reset_n, 1'b1);
    @(posedge clock_i) #1;
    check(pattern, 24'h1);
    wait_for(1, 24'h0, n);
    check(halted, 1'b1);
    check(pattern, 24'hd);
    check(running, 1'b0);
    check(seg_pat.size(), 32'hc);
    for (int i = 0; i < 11; i++) begin
      check(seg_pat[i + 1], exp_pat[i]);
      check(seg_len[i + 1], exp_len[i]);
    end
    // a trigger while halted restarts at address zero; stop then ends that run
    u_psc_host_model.pulse(2);
    wait_for(0, 24'h1, n);
    check(n, 32'h2);
    // second program: trigger wait, restart pin and header trigger
    u_psc_host_model.pulse(1);
    repeat (3) @(posedge clock_i);
    #1 check(reset_n, 1'b0);
    check(halted, 1'b0);
    u_psc_host_model.load(10'h0, 4'h0, 20'h0, 24'h11, 32'h5);
    u_psc_host_model.load(10'h1, 4'h8, 20'h0, 24'h12, 32'h9);
    u_psc_host_model.load(10'h2, 4'h0, 20'h0, 24'h13, 32'h5);
    u_psc_host_model.load(10'h3, 4'h6, 20'h3, 24'h14, 32'h5);
    u_psc_host_model.pulse(0);
    wait_for(2, 24'h0, n);
    check(pattern, 24'h12);
    check(running, 1'b0);
    u_psc_host_model.pulse(0);
    repeat (5) @(posedge clock_i);
    #1 check(waiting, 1'b1);
    u_psc_host_model.pulse(2);
    wait_for(0, 24'h13, n);
    check(n, 32'(psc_pkg::WAIT_FIXED + 9 + 2));
    check(waiting, 1'b0);
    wait_for(0, 24'h14, n);
    check(n, 32'h5);
    u_psc_host_model.pin_low(1'b1);
    repeat (3) @(posedge clock_i);
    #1 check(running, 1'b0);
    check(reset_n, 1'b0);
    u_psc_host_model.pin_low(1'b0);
    wait_for(0, 24'h11, n);
    wait_for(2, 24'h0, n);
    u_psc_host_model.pin_low(1'b0);
    wait_for(0, 24'h13, n);
    check(waiting, 1'b0);
    wrap_up();
  end
endmodule : psc_core_tb_top
